//--- verilog/tcc_pkg.sv
// constants shared by the timer channel and its testbench
// assumes a single 100 MHz pclk domain and an APB slave port
// How it works
// RL1: initialization loads latches, clears channel flag
// RL2: timer reset always forces counter initialization
// RL3: counter at zero reloads on next clock
// RL4: control bits 3,4,5 pick operating mode
// RL5: bits 3 and 5 zero mean continuous
// RL6: output enable drives pin; bit2 picks shape
// RL7: init on reset, gate fall, latch write
// RL8: count only without reset and gate low; the code also counts with the gate high in single-shot (bit5 set)
// RL9: 16-bit mode decrements every enabled clock
// RL10: time-out sets flag and reloads counter
// RL11: dual mode: low byte zero reloads, high decrements
// RL12: dual output high after high byte zero
// RL13: zero low latch: time-out every M+1 clocks
// RL14: both latches zero: output toggles each clock
// RL15: counting independent of output enable bit
// RL16: 16-bit output toggles each time-out
// RL17: gate synchronised, falling edge one cycle
// RL18: reset pin loads latch with maximum count
// RL19: high buffer moves to latch on low write
// RL20: composite flag is channel flag and enable
package tcc_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] MSB_OFF = 8'h08;
  localparam logic [7:0] LATCH_OFF = 8'h0C;
  localparam logic [7:0] CNT_OFF = 8'h10;
  // control register bit positions
  localparam int RST_BIT = 0;
  localparam int DUAL_BIT = 2;
  localparam int MEAS_BIT = 3;
  localparam int INIT_BIT = 4;
  localparam int SHOT_BIT = 5;
  localparam int IE_BIT = 6;
  localparam int OE_BIT = 7;
  // status register bit positions
  localparam int FLAG_BIT = 0;
  localparam int INT_BIT = 7;
  // values after reset, and the synchroniser stage count
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [15:0] LATCH_RST = 16'hFFFF;
  localparam logic [7:0] MSB_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'hFFFF;
  localparam int SYNC_STAGES = 2;
endpackage

//--- verilog/tcc_sync.sv
// two-flop synchroniser for asynchronous pin levels
// assumes the pins are levels that stay put for several pclk cycles
`timescale 1ns/100ps
`default_nettype none
module tcc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic [W-1:0] pin_in, // raw pin levels
  output logic [W-1:0] pin_sync // synchronised levels
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
    end
  end

  assign pin_sync = sync_r;
endmodule
`default_nettype wire

//--- verilog/tcc_top.sv
// one programmable timer channel with its APB register file
// assumes pin inputs are asynchronous; counting clock is pclk itself
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module tcc_top (
  input wire logic pclk, // system clock, counting clock too
  input wire logic presetn, // async reset, active low
  input wire logic [7:0] paddr, // APB byte address
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic external_reset_pin_n, // timer reset pin, low active
  input wire logic timer_gate_n, // gate pin, low enables counting
  output logic timer_wave_output // timer output pin
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] msb_buf;
    logic [15:0] latch;
    logic [15:0] cnt;
    logic flag;
    logic armed;
    logic out;
    logic pin;
    logic gate_d;
    logic [15:0] rdata;
    logic err;
  } tcc_state_t;

  tcc_state_t st_r;
  tcc_state_t st_nxt;
  logic [1:0] sync_pins;
  logic rst_pin_low;
  logic gate_hi;
  logic reset_cond;
  logic gate_fall;
  logic setup;
  logic wr;
  logic rd;
  logic latch_wr;
  logic synth;
  logic cont;
  logic dual;
  logic init_now;
  logic en;
  logic timeout;

  // both pins pass two flops; reset pin starts asserted
  tcc_sync #(
    .W(2),
    .RST_VAL(2'h2)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({timer_gate_n, external_reset_pin_n}),
    .pin_sync(sync_pins)
  );

  // decoded conditions shared by the next-state logic and checks
  always_comb begin
    rst_pin_low = !sync_pins[0];
    gate_hi = sync_pins[1];
    reset_cond = rst_pin_low | st_r.ctrl[tcc_pkg::RST_BIT]; // RL2
    gate_fall = st_r.gate_d & !gate_hi; // RL17
    setup = psel & !penable;
    wr = psel & penable & pwrite;
    rd = psel & penable & !pwrite;
    latch_wr = wr && (paddr == tcc_pkg::LATCH_OFF);
    synth = !st_r.ctrl[tcc_pkg::MEAS_BIT]; // RL4
    cont = synth & !st_r.ctrl[tcc_pkg::SHOT_BIT]; // RL5
    dual = st_r.ctrl[tcc_pkg::DUAL_BIT]; // RL6
    // latch write triggers only with init select clear
    init_now = reset_cond | (synth & gate_fall)
      | (latch_wr & !st_r.ctrl[tcc_pkg::INIT_BIT]); // RL7
    // single-shot ignores the gate level; measurement is held
    en = !reset_cond & synth
      & (!gate_hi | st_r.ctrl[tcc_pkg::SHOT_BIT]); // RL8
    timeout = en & (st_r.cnt == 16'h0000); // RL10
  end

  // whole next state; order below sets priorities
  always_comb begin
    st_nxt = st_r;
    st_nxt.gate_d = gate_hi;
    // register writes take effect at the access edge
    if (wr && (paddr == tcc_pkg::CTRL_OFF)) begin
      st_nxt.ctrl = pwdata[7:0];
    end
    if (wr && (paddr == tcc_pkg::MSB_OFF)) begin
      st_nxt.msb_buf = pwdata[7:0];
    end
    if (latch_wr) begin
      st_nxt.latch = {st_r.msb_buf, pwdata[7:0]}; // RL19
    end
    // pin reset wins over any latch write
    if (rst_pin_low) begin
      st_nxt.latch = tcc_pkg::LATCH_RST; // RL18
    end
    // status read arms the flag clear for a later count read
    if (rd && (paddr == tcc_pkg::STAT_OFF)) begin
      st_nxt.armed = st_r.flag;
    end
    if (rd && (paddr == tcc_pkg::CNT_OFF) && st_r.armed) begin
      st_nxt.flag = 1'b0;
      st_nxt.armed = 1'b0;
    end
    // counter engine; same path whatever the output enable
    if (init_now) begin
      st_nxt.cnt = st_nxt.latch; // RL1
      st_nxt.flag = 1'b0; // RL1
      st_nxt.armed = 1'b0;
      st_nxt.out = 1'b0; // RL16
    end else if (timeout) begin
      // set after the read clear, so a coinciding event wins
      st_nxt.cnt = st_r.latch; // RL3
      st_nxt.flag = 1'b1; // RL10
      if (dual && (st_r.latch[7:0] != 8'h00)) begin
        st_nxt.out = 1'b0; // RL12
      end else begin
        st_nxt.out = !st_r.out; // RL13 RL14 RL16
      end
    end else if (en) begin
      if (!dual) begin
        st_nxt.cnt = st_r.cnt - 16'h0001; // RL9
      end else if (st_r.cnt[7:0] == 8'h00) begin
        st_nxt.cnt[7:0] = st_r.latch[7:0]; // RL11
        st_nxt.cnt[15:8] = st_r.cnt[15:8] - 8'h01; // RL11
      end else begin
        st_nxt.cnt[7:0] = st_r.cnt[7:0] - 8'h01;
        if (st_r.cnt[15:8] == 8'h00) begin
          st_nxt.out = 1'b1; // RL12
        end
      end
    end
    st_nxt.pin = st_nxt.out & st_nxt.ctrl[tcc_pkg::OE_BIT]; // RL6 RL15
    // read data captured in setup so prdata comes from a flop
    if (setup) begin
      st_nxt.err = 1'b0;
      st_nxt.rdata = 16'h0000;
      case (paddr)
        tcc_pkg::CTRL_OFF: st_nxt.rdata = {8'h00, st_r.ctrl};
        tcc_pkg::STAT_OFF: begin
          st_nxt.rdata[tcc_pkg::FLAG_BIT] = st_r.flag;
          st_nxt.rdata[tcc_pkg::INT_BIT] =
            st_r.flag & st_r.ctrl[tcc_pkg::IE_BIT]; // RL20
        end
        tcc_pkg::CNT_OFF: st_nxt.rdata = st_r.cnt; // RL15
        tcc_pkg::MSB_OFF: st_nxt.rdata = 16'h0000;
        tcc_pkg::LATCH_OFF: st_nxt.rdata = 16'h0000;
        default: st_nxt.err = 1'b1;
      endcase
    end
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{ctrl: tcc_pkg::CTRL_RST, msb_buf: tcc_pkg::MSB_RST,
        latch: tcc_pkg::LATCH_RST, cnt: tcc_pkg::CNT_RST,
        flag: 1'b0, armed: 1'b0, out: 1'b0, pin: 1'b0,
        gate_d: 1'b1, rdata: 16'h0000, err: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // zero-wait access phase; data already held since setup
  assign pready = psel & penable;
  assign pslverr = psel & penable & st_r.err;
  assign prdata = {16'h0000, st_r.rdata};
  assign timer_wave_output = st_r.pin;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_both_zero;
    en && dual && !init_now && (st_r.latch == 16'h0000)
      && (st_r.cnt == 16'h0000);
  endsequence

  sequence s_dual_borrow;
    en && dual && !init_now && !timeout && (st_r.cnt[7:0] == 8'h00);
  endsequence

  a_init_loads: assert property (init_now |=> // RL1
    (st_r.cnt == $past(st_nxt.latch)) && !st_r.flag && !st_r.out)
    else $error("initialization did not load counter");

  a_reset_holds: assert property (reset_cond ##1 reset_cond |-> // RL2
    !st_r.flag && (st_r.cnt == $past(st_nxt.latch)))
    else $error("reset did not hold counter initialized");

  a_zero_reload: assert property (timeout && !init_now |=> // RL3
    (st_r.cnt == $past(st_r.latch)) && st_r.flag)
    else $error("time-out did not reload and flag");

  a_measure_hold: assert property (st_r.ctrl[tcc_pkg::MEAS_BIT] // RL4
    && !init_now |=> (st_r.cnt == $past(st_r.cnt)))
    else $error("counter moved in measurement mode");

  a_gate_fall_init: assert property (cont && gate_fall |=> // RL7
    !st_r.flag && (st_r.cnt == $past(st_nxt.latch)))
    else $error("gate fall did not initialize");

  a_gate_high_hold: assert property (gate_hi && cont && !init_now // RL8
    |=> (st_r.cnt == $past(st_r.cnt)))
    else $error("counter moved with gate high");

  a_count_down: assert property (en && !dual && !init_now // RL9
    && !timeout |=> (st_r.cnt == $past(st_r.cnt) - 16'h0001))
    else $error("16-bit count did not decrement");

  a_dual_borrow: assert property (s_dual_borrow |=> // RL11
    (st_r.cnt[7:0] == $past(st_r.latch[7:0])) &&
    (st_r.cnt[15:8] == $past(st_r.cnt[15:8]) - 8'h01))
    else $error("dual borrow wrong");

  a_dual_high: assert property (en && dual && !init_now && !timeout // RL12
    && (st_r.cnt[15:8] == 8'h00) |=> st_r.out)
    else $error("dual output not high");

  a_toggle_out: assert property (timeout && !init_now && // RL16
    (!dual || (st_r.latch[7:0] == 8'h00)) |=> st_r.out != $past(st_r.out))
    else $error("output did not toggle at time-out");

  a_both_zero: assert property (s_both_zero ##1 s_both_zero |=> // RL14
    (st_r.cnt == 16'h0000) && (st_r.out == $past(st_r.out, 2)))
    else $error("zero latch toggle wrong");

  a_pin_reset_max: assert property (rst_pin_low |=> // RL18
    st_r.latch == tcc_pkg::LATCH_RST)
    else $error("reset pin did not preset latch");

  a_msb_transfer: assert property (latch_wr && !rst_pin_low |=> // RL19
    st_r.latch == {$past(st_r.msb_buf), $past(pwdata[7:0])})
    else $error("latch write did not pair bytes");

  a_pin_gate: assert property (1'b1 |-> // RL6
    timer_wave_output == (st_r.out && st_r.ctrl[tcc_pkg::OE_BIT]))
    else $error("output pin not gated by enable");

  a_fall_pulse: assert property (gate_fall |=> !gate_fall) // RL17
    else $error("gate edge longer than one cycle");

  // host reads and writes, seen one edge after setup or access
  sequence s_cnt_setup;
    setup && (paddr == tcc_pkg::CNT_OFF);
  endsequence

  sequence s_stat_setup;
    setup && (paddr == tcc_pkg::STAT_OFF);
  endsequence

  sequence s_bad_access;
    setup && (paddr > tcc_pkg::CNT_OFF) ##1 (psel && penable);
  endsequence

  a_count_read: assert property (s_cnt_setup |=> // RL15
    prdata[15:0] == $past(st_r.cnt))
    else $error("counter read data wrong");

  a_status_compose: assert property (s_stat_setup |=> // RL20
    (prdata[tcc_pkg::FLAG_BIT] == $past(st_r.flag)) &&
    (prdata[tcc_pkg::INT_BIT] ==
      $past(st_r.flag && st_r.ctrl[tcc_pkg::IE_BIT])))
    else $error("status read data wrong");

  a_ctrl_write: assert property (wr && (paddr == tcc_pkg::CTRL_OFF) // RL4
    |=> st_r.ctrl == $past(pwdata[7:0]))
    else $error("control write lost");

  // refused access: error flagged, read data zero
  a_unmapped_error: assert property (s_bad_access |->
    pslverr && (prdata == 32'h00000000))
    else $error("unmapped access not refused");

  // flag set and clear; a time-out beats a clearing read
  a_flag_set_wins: assert property (timeout && !init_now && rd // RL10
    && (paddr == tcc_pkg::CNT_OFF) |=> st_r.flag)
    else $error("read clear beat time-out");

  a_flag_read_clear: assert property (rd && (paddr == tcc_pkg::CNT_OFF)
    && st_r.armed && !timeout && !init_now |=> !st_r.flag)
    else $error("armed counter read kept flag");

  a_measure_no_flag: assert property (st_r.ctrl[tcc_pkg::MEAS_BIT] // RL4
    && !init_now && !st_r.flag |=> !st_r.flag)
    else $error("flag set in measurement mode");

  // output pin and counting engine
  a_pin_masked: assert property (!st_r.ctrl[tcc_pkg::OE_BIT] |-> // RL6 RL15
    !timer_wave_output)
    else $error("masked output pin went high");

  a_init_out_low: assert property (init_now |=> // RL16
    !timer_wave_output)
    else $error("output not low after initialization");

  a_ext_pin_init: assert property (rst_pin_low |=> // RL2
    (st_r.cnt == tcc_pkg::LATCH_RST) && !st_r.flag)
    else $error("reset pin did not initialize counter");

  a_cont_enable: assert property (cont && !reset_cond && !gate_hi // RL5 RL8
    && !init_now && (st_r.cnt != 16'h0000) |=> st_r.cnt != $past(st_r.cnt))
    else $error("continuous counter stalled");

  // single-shot runs whatever the gate level
  a_shot_count: assert property (synth && st_r.ctrl[tcc_pkg::SHOT_BIT] // RL4
    && !reset_cond && !init_now && !dual && (st_r.cnt != 16'h0000)
    |=> st_r.cnt == $past(st_r.cnt) - 16'h0001)
    else $error("single-shot counter did not run");

  // high byte waits for the low byte to borrow
  a_dual_hold_high: assert property (en && dual && !init_now // RL11
    && (st_r.cnt[7:0] != 8'h00) |=> st_r.cnt[15:8] == $past(st_r.cnt[15:8]))
    else $error("high byte moved before borrow");

  // zero low latch: the low byte never reloads nonzero
  a_low_zero_borrow: assert property (en && dual && !init_now // RL13
    && !timeout && (st_r.latch[7:0] == 8'h00) && (st_r.cnt[7:0] == 8'h00)
    |=> (st_r.cnt[7:0] == 8'h00) &&
    (st_r.cnt[15:8] == $past(st_r.cnt[15:8]) - 8'h01))
    else $error("zero low latch count wrong");

  a_dual_timeout_low: assert property (dual && timeout && !init_now // RL12
    && (st_r.latch[7:0] != 8'h00) |=> !st_r.out)
    else $error("dual output not low at time-out");

  // latch and buffer keep their contents
  a_latch_keep: assert property (st_r.ctrl[tcc_pkg::RST_BIT] // RL18
    && !rst_pin_low && !latch_wr |=> st_r.latch == $past(st_r.latch))
    else $error("internal reset bit touched latch");

  a_msb_keep: assert property (latch_wr |=> // RL19
    st_r.msb_buf == $past(st_r.msb_buf))
    else $error("buffer changed by latch write");
endmodule
`default_nettype wire

//--- tb/tcc_host.sv
// bus master model standing in for the host processor
// assumes the slave may stretch the access phase by holding pready low
`timescale 1ns/100ps
`default_nettype none
module tcc_host (
  input wire logic pclk, // system clock
  output logic [7:0] paddr, // byte address
  output logic psel, // select
  output logic penable, // access phase
  output logic pwrite, // direction
  output logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr // error
);
  // idle bus at time zero
  initial begin
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h00000000;
  end
  // one transfer; request held until pready is seen high
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
            output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~pwdata; // released data must not look valid
  endtask
  // high byte first, low byte write moves it into the latch
  task load(input logic [15:0] v);
    logic [31:0] r;
    logic e;
    xfer(1'b1, tcc_pkg::MSB_OFF, v[15:8], r, e);
    xfer(1'b1, tcc_pkg::LATCH_OFF, v[7:0], r, e);
  endtask
endmodule
`default_nettype wire

//--- tb/timer_counter_continuous_mode_bench.sv
// self-checking bench for one continuous-mode timer channel
// assumes zero-wait bus answers may vary; output measured at pclk
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
module timer_counter_continuous_mode_bench;
  logic pclk, presetn, ext_n, gate_n, wave, psel, penable, pwrite;
  logic pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, c1;
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;
  int n, l, m, g;
  tcc_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_reset_pin_n(ext_n), .timer_gate_n(gate_n),
    .timer_wave_output(wave));
  tcc_host host (.pclk(pclk), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // hang guard; runs stay well below a few thousand cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task tally_and_finish;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, rd, er);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 8'h00, rd, er);
    `CHK(rd, exp)
  endtask
  // cycles between the next two qualifying output changes
  task tgap(input logic rise, output int k);
    logic p;
    logic hit;
    for (int j = 0; j < 2; j++) begin
      k = 0;
      hit = 1'b0;
      while (!hit && k < 5000) begin
        p = wave;
        @(posedge pclk);
        #1;
        k++;
        hit = (wave !== p) && (!rise || wave === 1'b1);
      end
    end
  endtask
  // expected half period, or rise-to-rise period for dual shape with nonzero low latch
  function automatic int half_exp(logic dual, int lo, int hi);
    if (!dual) return hi * 256 + lo + 1;
    if (lo == 0) return hi + 1;
    return (lo + 1) * (hi + 1);
  endfunction
  // main sequence
  initial begin
    presetn = 1'b0;
    ext_n = 1'b1;
    gate_n = 1'b1;
    void'($urandom(66));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(tcc_pkg::CTRL_OFF, 32'h00000001);
    rdchk(tcc_pkg::CNT_OFF, 32'h0000FFFF);
    rdchk(tcc_pkg::STAT_OFF, 32'h00000000);
    host.xfer(1'b0, 8'h40, 8'h00, rd, er);
    `CHK(er, 1'b1)
    $display("test reset values done");
    // latch write inits only when bit4 clear; gate high holds count
    n = $urandom_range(9, 2);
    wr(tcc_pkg::CTRL_OFF, 8'h80);
    host.load(n[15:0]);
    rdchk(tcc_pkg::CNT_OFF, n);
    rdchk(tcc_pkg::STAT_OFF, 32'h00000000);
    wr(tcc_pkg::CTRL_OFF, 8'h90);
    host.load(n[15:0] + 16'h0003);
    rdchk(tcc_pkg::CNT_OFF, n);
    @(posedge pclk);
    gate_n <= 1'b0;
    tgap(1'b0, g);
    `CHK(g, half_exp(1'b0, n + 3, 0))
    rdchk(tcc_pkg::STAT_OFF, 32'h00000001);
    wr(tcc_pkg::CTRL_OFF, 8'hD0);
    rdchk(tcc_pkg::STAT_OFF, 32'h00000081);
    // output disabled: counting and flags carry on
    wr(tcc_pkg::CTRL_OFF, 8'h00);
    host.xfer(1'b0, tcc_pkg::CNT_OFF, 8'h00, rd, er);
    repeat (2 * n + 8) @(posedge pclk);
    rdchk(tcc_pkg::STAT_OFF, 32'h00000001);
    `CHK(wave, 1'b0)
    // measure mode freezes the counter
    wr(tcc_pkg::CTRL_OFF, 8'h08);
    host.xfer(1'b0, tcc_pkg::CNT_OFF, 8'h00, c1, er);
    rdchk(tcc_pkg::CNT_OFF, c1);
    $display("test sixteen bit done");
    // dual byte shapes: general, zero low latch, both zero
    for (int c = 0; c < 3; c++) begin
      l = (c == 0) ? $urandom_range(5, 1) : 0;
      m = (c == 2) ? 0 : $urandom_range(4, 1);
      @(posedge pclk);
      gate_n <= 1'b1;
      wr(tcc_pkg::CTRL_OFF, 8'h84);
      host.load({m[7:0], l[7:0]});
      @(posedge pclk);
      gate_n <= 1'b0;
      tgap(c == 0, g);
      `CHK(g, half_exp(1'b1, l, m))
    end
    $display("test dual byte done");
    // single-shot counts with the gate high, first clock after init
    @(posedge pclk);
    gate_n <= 1'b1;
    wr(tcc_pkg::CTRL_OFF, 8'hA0);
    host.load(16'h0040);
    rdchk(tcc_pkg::CNT_OFF, 32'h0000003F);
    $display("test single shot done");
    // internal bit holds counter at latch; pin presets the latch
    wr(tcc_pkg::CTRL_OFF, 8'h01);
    host.load(16'h1234);
    rdchk(tcc_pkg::CNT_OFF, 32'h00001234);
    @(posedge pclk);
    ext_n <= 1'b0;
    repeat (4) @(posedge pclk);
    ext_n <= 1'b1;
    repeat (4) @(posedge pclk);
    rdchk(tcc_pkg::CNT_OFF, 32'h0000FFFF);
    $display("test timer reset done");
    tally_and_finish();
  end
endmodule
`undef CHK
`default_nettype wire
